/* File: logic/dplc_pkg.sv */
package dplc_pkg;

  // ************************************************************
  // Security command opcodes, consecutive from set password.
  // ************************************************************
  localparam logic [7:0] CMD_SET_PASSWORD = 8'hf1;
  localparam logic [7:0] CMD_UNLOCK = 8'hf2;
  localparam logic [7:0] CMD_ERASE_PREPARE = 8'hf3;
  localparam logic [7:0] CMD_ERASE_UNIT = 8'hf4;
  localparam logic [7:0] CMD_FREEZE_LOCK = 8'hf5;
  localparam logic [7:0] CMD_DISABLE_PASSWORD = 8'hf6;

  // ************************************************************
  // Identify words, field positions and limits.
  // ************************************************************
  localparam logic [7:0] ID_WORD_MASTER_REV = 8'h5c;
  localparam logic [7:0] ID_WORD_SECURITY = 8'h80;
  localparam int EXPIRED_BIT = 4;
  localparam logic [15:0] MASTER_REV_DEFAULT = 16'hfffe;
  localparam logic [15:0] MASTER_REV_MIN = 16'h0001;
  localparam logic [15:0] MASTER_REV_MAX = 16'hfffe;
  localparam logic [2:0] MISMATCH_LIMIT = 3'h5;
  localparam int PW_W = 32;

  // ************************************************************
  // Security modes.
  // ************************************************************
  typedef enum logic [1:0] {
    DPLC_UNLOCKED = 2'b00,
    DPLC_LOCKED = 2'b01,
    DPLC_FROZEN = 2'b10
  } dplc_mode_t;

  // Command from the host side of the drive's command interface.
  typedef struct packed {
    logic [7:0] opcode;
    logic media;
    logic max_addr;
    logic user_sel;
    logic level_max;
    logic [PW_W-1:0] password;
    logic [15:0] master_rev;
  } dplc_cmd_t;

  // Completion answer.
  typedef struct packed {
    logic done;
    logic aborted;
    logic erase;
  } dplc_rsp_t;

endpackage

/* File: logic/dplc_sync.sv */
`timescale 1ns/10ps

// ************************************************************
// Two-stage reset release synchroniser.
// ************************************************************
module dplc_sync (
  input wire logic mclk_i, // Clock.
  input wire logic rstn_i, // Asynchronous reset, active low.
  output logic rstn_o // Synchronised reset, active low.
);

  logic stage1_reg;
  logic stage2_reg;

  // Assert at once, release after two edges to avoid metastable release.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end
    else
    begin
      stage1_reg <= 1'b1;
      stage2_reg <= stage1_reg;
    end
  end

  assign rstn_o = stage2_reg;

endmodule // dplc_sync

/* File: logic/dplc_lock.sv */
`timescale 1ns/10ps

module dplc_lock (
  input wire logic mclk_i, // 125 MHz clock.
  input wire logic rstn_i, // Power-on or hard reset, active low.
  input wire logic cmd_valid_i, // One-cycle command strobe.
  input wire dplc_pkg::dplc_cmd_t cmd_i, // Command contents.
  input wire logic [7:0] id_word_i, // Identify word index.
  output dplc_pkg::dplc_rsp_t rsp_o, // Completion, one cycle.
  output logic [15:0] id_data_o, // Identify word value.
  output dplc_pkg::dplc_mode_t mode_o, // Current security mode.
  output logic lock_enabled_o, // Lock function enabled.
  output logic level_max_o, // Maximum security level.
  output logic unlock_attempts_expired_o // Attempt limit reached.
);

  logic rstn;
  dplc_pkg::dplc_mode_t mode_reg, mode_next;
  logic lock_en_reg, lock_en_next;
  logic level_max_reg, level_max_next;
  logic [dplc_pkg::PW_W-1:0] user_pw_reg, user_pw_next;
  logic [dplc_pkg::PW_W-1:0] master_pw_reg, master_pw_next;
  logic [15:0] master_rev_reg, master_rev_next;
  logic [2:0] miss_reg, miss_next;
  logic expired_reg, expired_next;
  logic prep_reg, prep_next;
  logic booted_reg, booted_next;
  dplc_pkg::dplc_rsp_t rsp_reg, rsp_next;
  logic [15:0] id_reg, id_next;

  // ************************************************************
  // Reset release.
  // ************************************************************
  dplc_sync u_sync (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .rstn_o(rstn)
  );

  // ************************************************************
  // Security state machine.
  // ************************************************************
  logic user_ok, master_ok, cred_ok, is_sec;

  // Password stores survive reset so the lock takes effect at the next reset,
  // standing in for the nonvolatile store of a real drive.
  always_comb
  begin
    mode_next = mode_reg;
    lock_en_next = lock_en_reg;
    level_max_next = level_max_reg;
    user_pw_next = user_pw_reg;
    master_pw_next = master_pw_reg;
    master_rev_next = master_rev_reg;
    miss_next = miss_reg;
    expired_next = expired_reg;
    prep_next = prep_reg;
    booted_next = 1'b1;
    rsp_next = '0;
    user_ok = (cmd_i.password == user_pw_reg) && lock_en_reg;
    master_ok = (cmd_i.password == master_pw_reg);
    cred_ok = cmd_i.user_sel ? user_ok : master_ok;
    is_sec = (cmd_i.opcode >= dplc_pkg::CMD_SET_PASSWORD) &&
             (cmd_i.opcode <= dplc_pkg::CMD_DISABLE_PASSWORD);
    // First cycle after reset: locked only when a user password exists.
    if (!booted_reg)
    begin
      mode_next = lock_en_reg ? dplc_pkg::DPLC_LOCKED : dplc_pkg::DPLC_UNLOCKED;
    end
    else if (cmd_valid_i)
    begin
      rsp_next.done = 1'b1;
      if (is_sec && cmd_i.opcode != dplc_pkg::CMD_ERASE_UNIT)
      begin
        prep_next = 1'b0;
      end
      case (cmd_i.opcode)
        dplc_pkg::CMD_SET_PASSWORD:
        begin
          if (mode_reg != dplc_pkg::DPLC_UNLOCKED)
          begin
            rsp_next.aborted = 1'b1;
          end
          else if (cmd_i.user_sel)
          begin
            user_pw_next = cmd_i.password;
            lock_en_next = 1'b1;
            level_max_next = cmd_i.level_max;
          end
          else
          begin
            master_pw_next = cmd_i.password;
            if (cmd_i.master_rev >= dplc_pkg::MASTER_REV_MIN &&
                cmd_i.master_rev <= dplc_pkg::MASTER_REV_MAX)
            begin
              master_rev_next = cmd_i.master_rev;
            end
          end
        end
        dplc_pkg::CMD_UNLOCK:
        begin
          if (mode_reg == dplc_pkg::DPLC_FROZEN || expired_reg)
          begin
            rsp_next.aborted = 1'b1;
          end
          else if (cmd_i.user_sel ? user_ok : (master_ok && !level_max_reg))
          begin
            mode_next = dplc_pkg::DPLC_UNLOCKED;
          end
          else
          begin
            rsp_next.aborted = 1'b1;
            miss_next = miss_reg + 3'h1;
            expired_next = (miss_next == dplc_pkg::MISMATCH_LIMIT);
          end
        end
        dplc_pkg::CMD_ERASE_PREPARE:
        begin
          if (mode_reg == dplc_pkg::DPLC_FROZEN)
          begin
            rsp_next.aborted = 1'b1;
          end
          else
          begin
            prep_next = 1'b1;
          end
        end
        dplc_pkg::CMD_ERASE_UNIT:
        begin
          prep_next = 1'b0;
          if (mode_reg == dplc_pkg::DPLC_FROZEN || expired_reg || !prep_reg)
          begin
            rsp_next.aborted = 1'b1;
          end
          else if (cred_ok)
          begin
            rsp_next.erase = 1'b1;
            mode_next = dplc_pkg::DPLC_UNLOCKED;
            lock_en_next = 1'b0;
            level_max_next = 1'b0;
          end
          else
          begin
            rsp_next.aborted = 1'b1;
            miss_next = miss_reg + 3'h1;
            expired_next = (miss_next == dplc_pkg::MISMATCH_LIMIT);
          end
        end
        dplc_pkg::CMD_FREEZE_LOCK:
        begin
          if (mode_reg == dplc_pkg::DPLC_LOCKED)
          begin
            rsp_next.aborted = 1'b1;
          end
          else
          begin
            mode_next = dplc_pkg::DPLC_FROZEN;
          end
        end
        dplc_pkg::CMD_DISABLE_PASSWORD:
        begin
          if (mode_reg != dplc_pkg::DPLC_UNLOCKED || !cred_ok)
          begin
            rsp_next.aborted = 1'b1;
          end
          else
          begin
            lock_en_next = 1'b0;
            level_max_next = 1'b0;
          end
        end
        default:
        begin
          // Frozen mode leaves ordinary media commands alone.
          if (mode_reg == dplc_pkg::DPLC_LOCKED && (cmd_i.media || cmd_i.max_addr))
          begin
            rsp_next.aborted = 1'b1;
          end
        end
      endcase
    end
  end

  // Identify word readout.
  always_comb
  begin
    id_next = 16'h0000;
    if (id_word_i == dplc_pkg::ID_WORD_MASTER_REV)
    begin
      id_next = master_rev_reg;
    end
    else if (id_word_i == dplc_pkg::ID_WORD_SECURITY)
    begin
      id_next[dplc_pkg::EXPIRED_BIT] = expired_reg;
    end
  end

  // Volatile state: mode, counter, expired flag cleared by every reset.
  always_ff @(posedge mclk_i or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_reg <= dplc_pkg::DPLC_UNLOCKED;
      miss_reg <= 3'h0;
      expired_reg <= 1'b0;
      prep_reg <= 1'b0;
      booted_reg <= 1'b0;
      rsp_reg <= '0;
      id_reg <= 16'h0000;
    end
    else
    begin
      mode_reg <= mode_next;
      miss_reg <= miss_next;
      expired_reg <= expired_next;
      prep_reg <= prep_next;
      booted_reg <= booted_next;
      rsp_reg <= rsp_next;
      id_reg <= id_next;
    end
  end

  // Persistent store: it has no reset, so passwords and the lock survive every
  // reset the way a nonvolatile store would. Without a power-on pin it comes
  // up unknown, so the host must program it before relying on it.
  always_ff @(posedge mclk_i)
  begin
    lock_en_reg <= lock_en_next;
    level_max_reg <= level_max_next;
    user_pw_reg <= user_pw_next;
    master_pw_reg <= master_pw_next;
    master_rev_reg <= master_rev_next;
  end

  assign rsp_o = rsp_reg;
  assign id_data_o = id_reg;
  assign mode_o = mode_reg;
  assign lock_enabled_o = lock_en_reg;
  assign level_max_o = level_max_reg;
  assign unlock_attempts_expired_o = expired_reg;

endmodule // dplc_lock

/* File: test/dplc_lock_properties.sv */
`timescale 1ns/10ps
// ****
// Lock checker.
// ****
module dplc_lock_properties (
  input wire logic mclk_i, // Clock.
  input wire logic rstn_i, // Reset.
  input wire logic cmd_valid_i, // Strobe.
  input wire dplc_pkg::dplc_cmd_t cmd_i, // Command.
  input wire logic [7:0] id_word_i, // Index.
  input wire dplc_pkg::dplc_rsp_t rsp_o, // Answer.
  input wire logic [15:0] id_data_o, // Word.
  input wire dplc_pkg::dplc_mode_t mode_o, // Mode.
  input wire logic lock_enabled_o, // Lock.
  input wire logic level_max_o, // Level.
  input wire logic unlock_attempts_expired_o // Expired.
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Freeze lock is left out here because frozen mode accepts it harmlessly.
  sequence frz_s;
    cmd_valid_i && mode_o == dplc_pkg::DPLC_FROZEN
      && cmd_i.opcode inside {8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf6};
  endsequence
  sequence lck_s;
    cmd_valid_i && mode_o == dplc_pkg::DPLC_LOCKED
      && (cmd_i.media || cmd_i.max_addr || cmd_i.opcode inside {8'hf1, 8'hf5, 8'hf6});
  endsequence
  sequence abort_s;
    rsp_o.done && rsp_o.aborted;
  endsequence
  rsp_once_a: assert property (cmd_valid_i |=> rsp_o.done) else $error("no answer");
  rsp_idle_a: assert property (!cmd_valid_i |=> !rsp_o.done) else $error("stray answer");
  frozen_abort_a: assert property (frz_s |=> abort_s) else $error("frozen accepted");
  locked_abort_a: assert property (lck_s |=> abort_s ##0 mode_o == dplc_pkg::DPLC_LOCKED)
    else $error("locked accepted");
  frozen_hold_a: assert property (mode_o == dplc_pkg::DPLC_FROZEN |=>
    mode_o == dplc_pkg::DPLC_FROZEN) else $error("left frozen");
  refuse_keep_a: assert property (rsp_o.aborted |-> $stable(mode_o)) else $error("mode moved");
  expired_hold_a: assert property (unlock_attempts_expired_o |=> unlock_attempts_expired_o)
    else $error("expired dropped");
  expired_abort_a: assert property (cmd_valid_i && unlock_attempts_expired_o
    && cmd_i.opcode inside {8'hf2, 8'hf4} |=> abort_s) else $error("expired accepted");
  master_nolock_a: assert property (cmd_valid_i && cmd_i.opcode == 8'hf1 && !cmd_i.user_sel
    && !lock_enabled_o |=> !lock_enabled_o) else $error("master locked");
  erase_open_a: assert property (rsp_o.erase |-> !lock_enabled_o
    && mode_o == dplc_pkg::DPLC_UNLOCKED) else $error("erase kept lock");
endmodule // dplc_lock_properties

/* File: test/dplc_host.sv */
`timescale 1ns/10ps
// ****
// Host issuing security and media commands.
// ****
module dplc_host (
  input wire logic mclk_i, // Clock.
  output logic cmd_valid_o, // Strobe.
  output dplc_pkg::dplc_cmd_t cmd_o // Command.
);
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  // One-cycle strobe; idle lines show the inverse so stale data is never trusted.
  task automatic issue(input dplc_pkg::dplc_cmd_t c);
    @(posedge mclk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_o = c;
    @(posedge mclk_i);
    #1;
    cmd_valid_o = 1'b0;
    cmd_o = ~c;
  endtask
endmodule // dplc_host

/* File: test/testbench.sv */
`timescale 1ns/10ps
module testbench;
  localparam dplc_pkg::dplc_mode_t UL = dplc_pkg::DPLC_UNLOCKED;
  localparam dplc_pkg::dplc_mode_t LK = dplc_pkg::DPLC_LOCKED;
  localparam dplc_pkg::dplc_mode_t FZ = dplc_pkg::DPLC_FROZEN;
  logic mclk_i;
  logic rstn_i;
  logic cmd_valid;
  dplc_pkg::dplc_cmd_t cmd;
  logic [7:0] id_word;
  dplc_pkg::dplc_rsp_t rsp;
  logic [15:0] id_data;
  dplc_pkg::dplc_mode_t mode;
  logic lock_en, lvl_max, expired, ab, er;
  int failures = 0;
  int num_checks = 0;
  logic [31:0] upw, mpw;
  logic [15:0] rev;
  logic [7:0] ops [7] = '{8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'h25};
  // ****
  // Clock, design and host.
  // ****
  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  dplc_lock dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .id_word_i(id_word), .rsp_o(rsp), .id_data_o(id_data), .mode_o(mode),
    .lock_enabled_o(lock_en), .level_max_o(lvl_max), .unlock_attempts_expired_o(expired));
  dplc_host host (.mclk_i(mclk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd));
  // ****
  // Helpers.
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want)
    begin
      failures++;
      $display("unexpected at %0t: got %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Only the media opcode in the table carries the media flag.
  function automatic logic [1:0] kd(input logic [7:0] op);
    return (op == 8'h25) ? 2'b10 : 2'b00;
  endfunction
  function automatic logic refused(input dplc_pkg::dplc_mode_t m, input logic [7:0] op,
    input logic [1:0] k);
    if (m == LK)
      return k != 2'b00 || op inside {8'hf1, 8'hf5, 8'hf6};
    if (m == FZ)
      return op inside {8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf6};
    return 1'b0;
  endfunction
  task automatic send(input logic [7:0] op, input logic [1:0] k, input logic usr,
    input logic lvl, input logic [31:0] pw);
    host.issue('{op, k[1], k[0], usr, lvl, pw, rev});
    check(rsp.done, 1'b1);
    ab = rsp.aborted;
    er = rsp.erase;
  endtask
  task automatic boot;
    rstn_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    #1 rstn_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
  endtask
  task automatic read_rev;
    id_word = 8'h5c;
    @(posedge mclk_i);
    #1;
    check(id_data, rev);
  endtask
  // ****
  // Scenarios.
  // ****
  initial
  begin
    rstn_i = 1'b0;
    id_word = 8'h00;
    void'($urandom(10));
    upw = $urandom;
    mpw = ~upw;
    rev = 16'($urandom_range(16'hfffe, 16'h0001));
    boot;
    send(8'hf1, 2'b00, 1'b0, 1'b0, mpw);
    send(8'hf1, 2'b00, 1'b1, 1'b0, upw);
    check(lock_en, 1'b1);
    read_rev;
    boot;
    check(mode, LK);
    foreach (ops[i])
      if (refused(LK, ops[i], kd(ops[i])))
      begin
        send(ops[i], kd(ops[i]), 1'b1, 1'b0, upw);
        check(ab, 1'b1);
        check(mode, LK);
      end
    send(8'hf9, 2'b01, 1'b1, 1'b0, upw);
    check(ab, 1'b1);
    for (int n = 1; n <= 5; n++)
    begin
      send(8'hf2, 2'b00, n[0], 1'b0, upw ^ 32'(n));
      check(expired, 1'(n == 5));
    end
    id_word = 8'h80;
    @(posedge mclk_i);
    #1;
    check(id_data, 16'h0010);
    send(8'hf2, 2'b00, 1'b1, 1'b0, upw);
    check(ab, 1'b1);
    boot;
    check(expired, 1'b0);
    check(id_data, 16'h0000);
    send(8'hf2, 2'b00, 1'b0, 1'b0, mpw);
    check(mode, UL);
    send(8'h25, 2'b10, 1'b1, 1'b0, upw);
    check(ab, 1'b0);
    send(8'hf5, 2'b00, 1'b1, 1'b0, upw);
    check(mode, FZ);
    foreach (ops[i])
    begin
      send(ops[i], kd(ops[i]), 1'b1, 1'b0, upw);
      check(ab, refused(FZ, ops[i], kd(ops[i])));
      check(mode, FZ);
    end
    boot;
    send(8'hf2, 2'b00, 1'b1, 1'b0, upw);
    check(mode, UL);
    send(8'hf1, 2'b00, 1'b1, 1'b1, upw);
    check(lvl_max, 1'b1);
    boot;
    send(8'hf2, 2'b00, 1'b0, 1'b0, mpw);
    check(mode, LK);
    send(8'hf3, 2'b00, 1'b0, 1'b0, mpw);
    send(8'hf4, 2'b00, 1'b0, 1'b0, mpw);
    check(er, 1'b1);
    check(mode, UL);
    rev = 16'($urandom_range(16'hfffe, 16'h0001));
    send(8'hf1, 2'b00, 1'b0, 1'b0, mpw);
    check(lock_en, 1'b0);
    read_rev;
    boot;
    check(mode, UL);
    complete_run;
  end
  // Guards against a hang; the run needs well under a thousand cycles.
  initial
  begin
    #100000;
    failures++;
    complete_run;
  end
endmodule // testbench
bind dplc_lock dplc_lock_properties chk (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .id_word_i(id_word_i), .rsp_o(rsp_o),
  .id_data_o(id_data_o), .mode_o(mode_o), .lock_enabled_o(lock_enabled_o),
  .level_max_o(level_max_o), .unlock_attempts_expired_o(unlock_attempts_expired_o));
